// ===== bench/smbw_mem_model.sv
// External memory model that answers strobe pulses with a wait stretch
`timescale 1ns/1ns
`default_nettype none
module smbw_mem_model (
	input  wire logic       sys_clk,
	input  wire logic       active,
	input  wire logic [5:0] wait_len,
	output logic            external_wait_n
);
	int   left = 0;
	logic was  = 1'b0;
	initial external_wait_n = 1'b1;
	always @(posedge sys_clk) begin
		#5;
		if (active && !was) begin
			left = wait_len;
		end
		was = active;
		// Pull-up holds the line high whenever the device is not stalling
		external_wait_n = (left == 0);
		if (left > 0) begin
			left--;
		end
	end
endmodule : smbw_mem_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the byte-lane and wait sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check_val((g), (e))
module testbench;
	logic       sys_clk, rst_b, req, req_write, req_boot, byte_access_type, external_wait_n;
	logic [1:0] req_lanes, external_wait_policy;
	logic [5:0] setup_cycles, pulse_cycles, hold_cycles, wait_len;
	logic       busy, done, refused, read_strobe_n, write_strobe_n;
	logic       lower_byte_write_strobe, upper_byte_write_strobe;
	logic       lower_byte_select_n, upper_byte_select_n;
	int         err_count = 0;
	int         tests_run = 0;
	wire logic  act = !read_strobe_n || !write_strobe_n || !lower_byte_write_strobe
		|| !upper_byte_write_strobe;

	smbw_ctrl DUT (.sys_clk, .rst_b, .req, .req_write, .req_lanes, .req_boot, .byte_access_type,
		.external_wait_policy, .setup_cycles, .pulse_cycles, .hold_cycles, .external_wait_n,
		.busy, .done, .refused, .read_strobe_n, .write_strobe_n, .lower_byte_write_strobe,
		.upper_byte_write_strobe, .lower_byte_select_n, .upper_byte_select_n);
	smbw_mem_model mem (.sys_clk, .active(act), .wait_len, .external_wait_n);

	task automatic check_val(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check_val

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	function automatic logic [3:0] exp_lanes(input logic b, input logic w, input logic [1:0] l);
		return b ? {w, ~(w & l[0]), ~(w & l[1]), 1'b0} : {w, ~w, ~l[0], ~l[1]};
	endfunction : exp_lanes

	task automatic run_access(input logic w, b, boot, input logic [1:0] l, p,
		input logic [5:0] s, pl, h, wl);
		int         n;
		int         lo;
		int         hi;
		logic       ref_exp;
		logic       got_ref;
		logic       seen;
		logic [3:0] obs;
		ref_exp = (boot && b) || (p[1] && h == 6'h00);
		lo = ref_exp ? 0 : pl + 1 + ((p == 2'h2 && wl != 0) ? wl - 1 : 0);
		hi = ref_exp ? 0 : pl + 1 + (p[1] ? wl + 3 : 0);
		n = 0;
		got_ref = 1'b0;
		seen = 1'b0;
		obs = 4'h0;
		@(posedge sys_clk);
		#5;
		{req, req_write, byte_access_type, req_boot, req_lanes} = {1'b1, w, b, boot, l};
		{external_wait_policy, setup_cycles, pulse_cycles, hold_cycles} = {p, s, pl, h};
		wait_len = wl;
		for (int i = 0; i < 600; i++) begin
			@(posedge sys_clk);
			#5;
			req = 1'b0;
			if (act) begin
				if (!seen) begin
					`CHK(busy, 1'b1);
					obs = b ? {read_strobe_n, lower_byte_write_strobe, upper_byte_write_strobe, 1'b0}
						: {read_strobe_n, write_strobe_n, lower_byte_select_n, upper_byte_select_n};
				end
				seen = 1'b1;
				n++;
			end
			got_ref = got_ref | (refused === 1'b1);
			if (done === 1'b1 || refused === 1'b1) break;
		end
		`CHK({busy, done | refused}, 2'h1);
		`CHK(got_ref, ref_exp);
		`CHK(n >= lo && n <= hi, 1'b1);
		if (!ref_exp) `CHK(obs, exp_lanes(b, w, l));
		$display("access ended after %0d strobe cycles", n);
	endtask : run_access

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end

	initial begin
		{rst_b, req, req_write, req_boot, byte_access_type, req_lanes} = 6'h00;
		{external_wait_policy, setup_cycles, pulse_cycles, hold_cycles, wait_len} = 26'h0;
		void'($urandom(18422));
		repeat (6) @(posedge sys_clk);
		#5 rst_b = 1'b1;
		repeat (3) @(posedge sys_clk);
		// Refusals, ignored wait beyond the pulse, then each wait policy
		run_access(1, 1, 1, 2'h3, 2'h0, 6'h0, 6'h3, 6'h1, 6'h0);
		run_access(0, 0, 0, 2'h1, 2'h2, 6'h0, 6'h4, 6'h0, 6'h5);
		run_access(1, 0, 0, 2'h2, 2'h3, 6'h1, 6'h4, 6'h0, 6'h5);
		run_access(1, 0, 0, 2'h3, 2'h0, 6'h0, 6'h3, 6'h0, 6'h9);
		run_access(0, 1, 0, 2'h3, 2'h1, 6'h1, 6'h3, 6'h1, 6'h6);
		run_access(1, 0, 0, 2'h1, 2'h2, 6'h0, 6'h5, 6'h1, 6'h4);
		run_access(0, 0, 0, 2'h2, 2'h3, 6'h2, 6'h4, 6'h2, 6'h7);
		run_access(0, 0, 1, 2'h3, 2'h0, 6'h0, 6'h3, 6'h1, 6'h0);
		for (int t = 0; t < 40; t++) begin
			run_access(1'($urandom % 2), 1'($urandom % 2), 1'(($urandom % 8) == 0),
				2'($urandom % 3 + 1), 2'($urandom % 4), 6'($urandom % 4),
				6'($urandom % 8 + 3), 6'($urandom % 4), 6'($urandom % 9));
		end
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire

// ===== rtl/smbw_ctrl.sv
// Static memory access sequencer with byte-lane strobes and external wait
`timescale 1ns/1ns
`default_nettype none
module smbw_ctrl (
	input  wire logic                             sys_clk,
	input  wire logic                             rst_b,
	input  wire logic                             req,
	input  wire logic                             req_write,
	input  wire logic [1:0]                       req_lanes,
	input  wire logic                             req_boot,
	input  wire logic                             byte_access_type,
	input  wire logic [1:0]                       external_wait_policy,
	input  wire logic [smbw_pkg::CNT_W-1:0]       setup_cycles,
	input  wire logic [smbw_pkg::CNT_W-1:0]       pulse_cycles,
	input  wire logic [smbw_pkg::CNT_W-1:0]       hold_cycles,
	input  wire logic                             external_wait_n,
	output logic                                  busy,
	output logic                                  done,
	output logic                                  refused,
	output logic                                  read_strobe_n,
	output logic                                  write_strobe_n,
	output logic                                  lower_byte_write_strobe,
	output logic                                  upper_byte_write_strobe,
	output logic                                  lower_byte_select_n,
	output logic                                  upper_byte_select_n
);
	logic                         rst_meta;
	logic                         rst_sync;
	logic                         wait_meta;
	logic                         wait_sync;
	smbw_pkg::smbw_state_t        state;
	smbw_pkg::smbw_state_t        next_state;
	logic [smbw_pkg::CNT_W-1:0]   count;
	logic [smbw_pkg::CNT_W-1:0]   next_count;
	logic                         wr;
	logic                         next_wr;
	logic                         style;
	logic                         next_style;
	logic [1:0]                   pol;
	logic [1:0]                   next_pol;
	logic [1:0]                   lanes;
	logic [1:0]                   next_lanes;
	logic                         next_done;
	logic                         next_refused;
	logic                         next_rd_n;
	logic                         next_we_n;
	logic [1:0]                   next_wr_n;
	logic [1:0]                   next_bs_n;
	logic [1:0]                   wr_n;
	logic [1:0]                   bs_n;
	logic                         stall;

	// Wait is honoured only for policies 10 and 11
	function automatic logic wait_on(input logic [1:0] p);
		return (p == smbw_pkg::WAIT_FROZEN) || (p == smbw_pkg::WAIT_READY);
	endfunction : wait_on

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Wait pin is asynchronous to the access sequencer
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			wait_meta <= 1'b1;
			wait_sync <= 1'b1;
		end else begin
			wait_meta <= external_wait_n;
			wait_sync <= wait_meta;
		end
	end

	assign stall = (state == smbw_pkg::SMBW_PULSE) && wait_on(pol) && !wait_sync;

	always_comb begin
		next_state   = state;
		next_count   = count;
		next_wr      = wr;
		next_style   = style;
		next_pol     = pol;
		next_lanes   = lanes;
		next_done    = 1'b0;
		next_refused = 1'b0;
		case (state)
			smbw_pkg::SMBW_IDLE: begin
				if (req) begin
					if ((req_boot && byte_access_type == smbw_pkg::STYLE_BYTE_WRITE)
						|| (wait_on(external_wait_policy) && hold_cycles == '0)) begin
						next_refused = 1'b1;
					end else begin
						next_state = smbw_pkg::SMBW_SETUP;
						next_count = setup_cycles;
						next_wr    = req_write;
						next_style = byte_access_type;
						next_pol   = external_wait_policy;
						next_lanes = req_lanes;
					end
				end
			end
			smbw_pkg::SMBW_SETUP: begin
				if (count == '0) begin
					next_state = smbw_pkg::SMBW_PULSE;
					next_count = pulse_cycles;
				end else begin
					next_count = count - 1'b1;
				end
			end
			smbw_pkg::SMBW_PULSE: begin
				// frozen pauses count, ready holds at end
				if (stall && (pol == smbw_pkg::WAIT_FROZEN || count == '0)) begin
					next_count = count;
				end else if (count == '0) begin
					next_state = smbw_pkg::SMBW_HOLD;
					next_count = hold_cycles;
				end else begin
					next_count = count - 1'b1;
				end
			end
			smbw_pkg::SMBW_HOLD: begin
				if (count == '0) begin
					next_state = smbw_pkg::SMBW_IDLE;
					next_done  = 1'b1;
				end else begin
					next_count = count - 1'b1;
				end
			end
			default: begin
				next_state = smbw_pkg::SMBW_IDLE;
			end
		endcase
	end

	always_comb begin
		next_rd_n = 1'b1;
		next_we_n = 1'b1;
		next_wr_n = smbw_pkg::RST_STROBES_N;
		next_bs_n = smbw_pkg::RST_STROBES_N;
		if (next_state == smbw_pkg::SMBW_PULSE) begin
			if (next_style == smbw_pkg::STYLE_BYTE_WRITE) begin
				// bit0 lane 0, bit1 lane 1
				next_rd_n = next_wr;
				next_wr_n = next_wr ? ~next_lanes : smbw_pkg::RST_STROBES_N;
			end else begin
				// bit0 lane 0, bit1 lane 1
				next_rd_n = next_wr;
				next_we_n = !next_wr;
				next_bs_n = ~next_lanes;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			state          <= smbw_pkg::SMBW_IDLE;
			count          <= smbw_pkg::RST_COUNT;
			wr             <= 1'b0;
			style          <= smbw_pkg::STYLE_BYTE_SELECT;
			pol            <= smbw_pkg::WAIT_OFF;
			lanes          <= 2'h0;
			done           <= 1'b0;
			refused        <= 1'b0;
			busy           <= 1'b0;
			read_strobe_n  <= 1'b1;
			write_strobe_n <= 1'b1;
			wr_n           <= smbw_pkg::RST_STROBES_N;
			bs_n           <= smbw_pkg::RST_STROBES_N;
		end else begin
			state          <= next_state;
			count          <= next_count;
			wr             <= next_wr;
			style          <= next_style;
			pol            <= next_pol;
			lanes          <= next_lanes;
			done           <= next_done;
			refused        <= next_refused;
			busy           <= (next_state != smbw_pkg::SMBW_IDLE);
			read_strobe_n  <= next_rd_n;
			write_strobe_n <= next_we_n;
			wr_n           <= next_wr_n;
			bs_n           <= next_bs_n;
		end
	end

	assign lower_byte_write_strobe = wr_n[0];
	assign upper_byte_write_strobe = wr_n[1];
	assign lower_byte_select_n     = bs_n[0];
	assign upper_byte_select_n     = bs_n[1];

	chk_frozen_count_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(stall && pol == smbw_pkg::WAIT_FROZEN) |=> (count == $past(count)
			&& state == smbw_pkg::SMBW_PULSE))
		else $error("frozen wait did not hold count");
	// ready mode holds last pulse cycle
	chk_ready_pulse_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(stall && pol == smbw_pkg::WAIT_READY && count == '0)
		|=> state == smbw_pkg::SMBW_PULSE)
		else $error("ready wait did not hold pulse");
	// setup and hold count on whatever wait does
	chk_wait_pulse_only: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state != smbw_pkg::SMBW_PULSE && state != smbw_pkg::SMBW_IDLE && count != '0)
		|=> (count == $past(count) - 1'b1 && state == $past(state)))
		else $error("wait acted outside pulse");
	chk_wait_off_ignored: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_PULSE && pol == smbw_pkg::WAIT_OFF && count == '0)
		|=> state == smbw_pkg::SMBW_HOLD)
		else $error("disabled wait stretched pulse");
	chk_boot_refused: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_IDLE && req && req_boot
			&& byte_access_type == smbw_pkg::STYLE_BYTE_WRITE)
		|=> refused && state == smbw_pkg::SMBW_IDLE)
		else $error("boot in byte write accepted");
	chk_hold_needed: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_IDLE && req && wait_on(external_wait_policy)
			&& hold_cycles == '0) |=> refused)
		else $error("wait access without hold accepted");
	// byte write never drives common write
	chk_bw_no_we: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_PULSE && style == smbw_pkg::STYLE_BYTE_WRITE)
		|-> write_strobe_n && bs_n == smbw_pkg::RST_STROBES_N)
		else $error("byte write drove select lines");
	chk_bw_lanes: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_PULSE && style == smbw_pkg::STYLE_BYTE_WRITE && wr)
		|-> wr_n == ~lanes)
		else $error("write strobe lanes wrong");
	chk_bs_lanes: assert property (@(posedge sys_clk) disable iff (!rst_sync)
		(state == smbw_pkg::SMBW_PULSE && style == smbw_pkg::STYLE_BYTE_SELECT)
		|-> bs_n == ~lanes && write_strobe_n == !wr && wr_n == smbw_pkg::RST_STROBES_N)
		else $error("byte select lanes wrong");
endmodule : smbw_ctrl
`default_nettype wire

// ===== rtl/smbw_pkg.sv
// Shared constants and types for the static memory byte-lane and wait block
package smbw_pkg;
	localparam int unsigned DATA_W            = 16;
	localparam int unsigned LANES             = 2;
	localparam int unsigned CNT_W             = 6;
	// Byte access type encodings
	localparam logic        STYLE_BYTE_SELECT = 1'b0;
	localparam logic        STYLE_BYTE_WRITE  = 1'b1;
	// External wait policy encodings
	localparam logic [1:0]  WAIT_OFF          = 2'h0;
	localparam logic [1:0]  WAIT_FROZEN       = 2'h2;
	localparam logic [1:0]  WAIT_READY        = 2'h3;
	// Reset values
	localparam logic [1:0]  RST_STROBES_N     = 2'h3;
	localparam logic [CNT_W-1:0] RST_COUNT    = 6'h00;
	typedef enum logic [1:0] {
		SMBW_IDLE  = 2'b00,
		SMBW_SETUP = 2'b01,
		SMBW_PULSE = 2'b11,
		SMBW_HOLD  = 2'b10
	} smbw_state_t;
endpackage : smbw_pkg
